// *** core/spc_pkg.sv ***
// ==========================================================================
// Shared constants and types for the slave serial/parallel converter.
// ==========================================================================
package spc_pkg;

    // ======================================================================
    // Widths and depths.
    // ======================================================================
    localparam int WORD_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W      = 5;

    // ======================================================================
    // Transfer lengths, in bits, for the length select.
    // ======================================================================
    localparam logic [CNT_W-1:0] LEN_16 = 5'h10;
    localparam logic [CNT_W-1:0] LEN_8  = 5'h08;

    // ======================================================================
    // Serial data pin source codes; any code with the high bit clear picks
    // the routed matrix signal.
    // ======================================================================
    localparam logic [1:0] SDIO_SHIFT = 2'h2;
    localparam logic [1:0] SDIO_ADC   = 2'h3;
    localparam int         SDIO_HI    = 1;

    // ======================================================================
    // Timing: the sync lead before a parallel load, rounded up to cycles.
    // ======================================================================
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         SYNC_LEAD_NS  = 20;
    localparam int         SYNC_CYCLES   = (SYNC_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] SYNC_LAST     = 2'(SYNC_CYCLES - 1);

    // ======================================================================
    // Reset values.
    // ======================================================================
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    // ======================================================================
    // Sequencer states, one-hot.
    // ======================================================================
    typedef enum logic [2:0] {
        SPC_IDLE = 3'b001,
        SPC_SYNC = 3'b010,
        SPC_XFER = 3'b100
    } spc_state_e;

    // ======================================================================
    // All state of the converter core.
    // ======================================================================
    typedef struct packed {
        spc_state_e        state;
        logic [1:0]        sync_cnt;
        logic [CNT_W-1:0]  bit_cnt;
        logic [WORD_W-1:0] rx_sr;
        logic [WORD_W-1:0] tx_sr;
        logic [WORD_W-1:0] par_word;
        logic              sdo_bit;
        logic              irq;
        logic              pin_out;
        logic              pin_oe;
    } spc_core_s;

    localparam spc_core_s CORE_RST = '{
        state:    SPC_IDLE,
        sync_cnt: 2'h0,
        bit_cnt:  5'h00,
        rx_sr:    WORD_RST,
        tx_sr:    WORD_RST,
        par_word: WORD_RST,
        sdo_bit:  1'b0,
        irq:      1'b0,
        pin_out:  1'b0,
        pin_oe:   1'b0
    };

    // Number of bits in one word for the given length select.
    function automatic logic [CNT_W-1:0] spc_len(input logic byte_mode);
        spc_len = byte_mode ? LEN_8 : LEN_16;
    endfunction

endpackage

// *** core/spc_edge.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Edge finder for a level that is already synchronous to mclk.
// ==========================================================================
module spc_edge
    import spc_pkg::*;
(
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst_n,
    // Level in, edge pulses out.
    input  wire logic level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic prev;
        logic armed;
    } spc_edge_s;

    spc_edge_s s_q;
    spc_edge_s s_d;

    // Remember last level; edges wait one cycle after reset, so a level
    // that is already high then does not show a false rise.
    always_comb begin
        s_d.prev  = level;
        s_d.armed = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Edges are pulses of one cycle, combinational from the live input.
    assign rise = s_q.armed & level & ~s_q.prev;
    assign fall = s_q.armed & ~level & s_q.prev;

endmodule
`default_nettype wire

// *** core/spc_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================================
// Synchronous FIFO with valid and ready on both sides.
// ==========================================================================
module spc_fifo
    import spc_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } spc_fifo_s;

    spc_fifo_s s_q;
    spc_fifo_s s_d;
    logic      push;
    logic      pop;

    // Full and empty follow the occupancy count, so both are exact.
    assign in_ready  = (s_q.count != FULL_CNT);
    assign out_valid = (s_q.count != '0);
    assign out_data  = s_q.mem[s_q.rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers wrap naturally because the depth is a power of two.
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr_ptr] = in_data;
            s_d.wr_ptr          = s_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            s_d.count = s_q.count + 1'b1;
        end else if (pop && !push) begin
            s_d.count = s_q.count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// *** core/spc_core.sv ***
// Behaviour
// - Polarity 0 idles low; phase 0 samples rising, phase 1 samples falling.
// - Polarity 1 idles high; phase 0 samples falling, phase 1 samples rising.
// - Phase 0 samples on the leading edge, phase 1 on the trailing edge.
// - Phase 0 allows only serial-in, parallel-out transfers.
// - Phase 1 allows both transfer directions.
// - A sync signal halts internal clocks before parallel data is loaded.
// - Buffer mode makes the parallel flops a one-clock data buffer.
// - Source select picks counter words at 0, converter data at 1.
// - Buffer flops are clocked by the routed buffer clock; low byte carries sample.
// - Length bit selects 16 bits at 0, low 8 bits at 1.
// - Direction bit selects serial-in at 0, serial-out at 1.
// - Pin source: 0x routed signal, 10 shift register, 11 converter serial.
// - Phase comes from one config bit, polarity from the next.
// - In phase 1 interrupt rises after the last bit's sampling edge.
// - Interrupt falls on the next word's first bit or chip select rise.
// - With pin source 11, or 10 in a serial-out frame, driver enabled after select falls, released after it rises; source 0x always drives.
// - Serial-in builds a 16-bit word: upper and lower byte groups.
// - Parallel-out 16-bit word: counter a low byte, counter b high byte.
// - Serial clock and chip select come from internal routed signals.
`timescale 1ns/1ns
`default_nettype none
module spc_core
    import spc_pkg::*;
(
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Configuration bits, fixed after power-up.
    input  wire logic              phase_select_bit,
    input  wire logic              polarity_select_bit,
    input  wire logic              buffer_mode_en,
    input  wire logic              par_src_adc,
    input  wire logic              byte_mode_8,
    input  wire logic              parallel_to_serial_mode,
    input  wire logic [1:0]        sdio_src_sel,
    // Routed link signals.
    input  wire logic              serial_clock,
    input  wire logic              chip_select_n_input,
    input  wire logic              serial_in_line,
    output logic                   serial_out_line,
    output logic                   serial_out_oe,
    output logic                   transfer_irq,
    // Other serial sources for the shared data pin.
    input  wire logic              matrix_out_bit,
    input  wire logic              adc_serial_bit,
    // Parallel sources and buffer clock.
    input  wire logic [BYTE_W-1:0] state_counter_a,
    input  wire logic [BYTE_W-1:0] state_counter_b,
    input  wire logic [BYTE_W-1:0] adc_word,
    input  wire logic              routed_buffer_clock,
    // Parallel results.
    output logic [WORD_W-1:0]      serial_to_parallel_word,
    output logic                   sync_hold,
    // Received word stream.
    output logic                   rx_space_ok,
    output logic                   rx_word_valid,
    input  wire logic              rx_word_ready,
    output logic [WORD_W-1:0]      rx_word_data
);

    // ======================================================================
    // Declarations.
    // ======================================================================
    spc_core_s         s_q;
    spc_core_s         s_d;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              bufclk_rise;
    logic              cs_active;
    logic              leading;
    logic              trailing;
    logic              sample_edge;
    logic              drive_edge;
    logic              p2s_eff;
    logic [CNT_W-1:0]  len;
    logic              word_done;
    logic              fifo_push;
    logic [WORD_W-1:0] rx_next;
    logic [WORD_W-1:0] rx_word;
    logic [WORD_W-1:0] parallel_load_word;

    // ======================================================================
    // Edge finders for the routed clocks.
    // ======================================================================
    // Serial clock and select reach us through the routing matrix, already
    // synchronous to mclk; the slow link keeps each level for many cycles.
    spc_edge u_sclk_edge (
        .mclk  (mclk),
        .rst_n (rst_n),
        .level (serial_clock),
        .rise  (sclk_rise),
        .fall  (sclk_fall)
    );

    spc_edge u_bufclk_edge (
        .mclk  (mclk),
        .rst_n (rst_n),
        .level (routed_buffer_clock),
        .rise  (bufclk_rise),
        .fall  ()
    );

    // ======================================================================
    // Mode decoding.
    // ======================================================================
    // Leading edge leaves the idle level, trailing edge returns to it.
    assign leading     = polarity_select_bit ? sclk_fall : sclk_rise;
    assign trailing    = polarity_select_bit ? sclk_rise : sclk_fall;
    assign sample_edge = phase_select_bit ? trailing : leading;
    assign drive_edge  = phase_select_bit ? leading : trailing;
    // Serial-out is only honoured with phase 1; phase 0 gives no time to
    // present the first bit before the first edge.
    assign p2s_eff     = parallel_to_serial_mode & phase_select_bit;
    assign len         = spc_len(byte_mode_8);
    assign cs_active   = ~chip_select_n_input;

    // Counter a fills the low byte, counter b the high byte.
    assign parallel_load_word = par_src_adc ? {BYTE_ZERO, adc_word}
                                            : {state_counter_b, state_counter_a};

    // Shift in most significant bit first.
    assign rx_next   = {s_q.rx_sr[WORD_W-2:0], serial_in_line};
    assign rx_word   = byte_mode_8 ? {BYTE_ZERO, rx_next[BYTE_W-1:0]} : rx_next;
    assign word_done = (s_q.state == SPC_XFER) && cs_active && sample_edge
                       && (s_q.bit_cnt == len - 1'b1);
    // A word arriving while the FIFO is full is dropped; rx_space_ok warns.
    assign fifo_push = word_done & ~p2s_eff;

    // ======================================================================
    // Sequencer and shifters.
    // ======================================================================
    // Every piece of state advances here; serial clock edges act only inside a frame.
    always_comb begin
        s_d = s_q;
        case (s_q.state)
            SPC_IDLE: begin
                s_d.bit_cnt  = '0;
                s_d.sync_cnt = 2'h0;
                if (cs_active) begin
                    s_d.state = p2s_eff ? SPC_SYNC : SPC_XFER;
                end
            end
            SPC_SYNC: begin
                // Internal clocks stay gated while the parallel word is caught.
                if (!cs_active) begin
                    s_d.state = SPC_IDLE;
                end else if (s_q.sync_cnt == SYNC_LAST) begin
                    s_d.tx_sr = byte_mode_8 ? {parallel_load_word[BYTE_W-1:0], BYTE_ZERO}
                                            : parallel_load_word;
                    s_d.state = SPC_XFER;
                end else begin
                    s_d.sync_cnt = s_q.sync_cnt + 1'b1;
                end
            end
            SPC_XFER: begin
                if (!cs_active) begin
                    s_d.state   = SPC_IDLE;
                    s_d.bit_cnt = '0;
                    s_d.irq     = 1'b0;
                end else begin
                    if (sample_edge) begin
                        s_d.rx_sr = rx_next;
                        if (word_done) begin
                            s_d.bit_cnt = '0;
                            // Buffer mode owns the parallel flops.
                            if (!p2s_eff && !buffer_mode_en) begin
                                if (byte_mode_8) begin
                                    s_d.par_word[BYTE_W-1:0] = rx_next[BYTE_W-1:0];
                                end else begin
                                    s_d.par_word = rx_next;
                                end
                            end
                            if (phase_select_bit) begin
                                s_d.irq = 1'b1;
                            end
                        end else begin
                            s_d.bit_cnt = s_q.bit_cnt + 1'b1;
                            if (s_q.bit_cnt == '0) begin
                                s_d.irq = 1'b0;
                            end
                        end
                    end
                    if (drive_edge && p2s_eff) begin
                        // Word is not reloaded mid-frame; later words shift zeros.
                        s_d.sdo_bit = s_q.tx_sr[WORD_W-1];
                        s_d.tx_sr   = {s_q.tx_sr[WORD_W-2:0], 1'b0};
                    end
                end
            end
            default: begin
                s_d.state = SPC_IDLE;
            end
        endcase

        // Buffer mode: flops sample the selected source on the routed clock.
        if (buffer_mode_en && bufclk_rise) begin
            s_d.par_word[BYTE_W-1:0] = par_src_adc ? adc_word : state_counter_a;
        end

        // Shared pin source and driver enable, registered.
        if (sdio_src_sel[SDIO_HI]) begin
            s_d.pin_out = (sdio_src_sel == SDIO_ADC) ? adc_serial_bit : s_d.sdo_bit;
            s_d.pin_oe  = cs_active && ((sdio_src_sel == SDIO_ADC) || p2s_eff);
        end else begin
            s_d.pin_out = matrix_out_bit;
            s_d.pin_oe  = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs.
    // ======================================================================
    assign serial_out_line         = s_q.pin_out;
    assign serial_out_oe           = s_q.pin_oe;
    assign transfer_irq            = s_q.irq;
    assign serial_to_parallel_word = s_q.par_word;
    assign sync_hold               = (s_q.state == SPC_SYNC);

    // ======================================================================
    // Received word FIFO.
    // ======================================================================
    // The drain side may stall; once full, new words are lost.
    spc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (fifo_push),
        .in_ready  (rx_space_ok),
        .in_data   (rx_word),
        .out_valid (rx_word_valid),
        .out_ready (rx_word_ready),
        .out_data  (rx_word_data)
    );

    // ======================================================================
    // Checks.
    // ======================================================================
    property p_irq_after_lsb;
        @(posedge mclk) disable iff (!rst_n)
        (word_done && phase_select_bit) |=> transfer_irq;
    endproperty
    a_irq_after_lsb: assert property (p_irq_after_lsb)
        else $error("interrupt did not rise after the last bit");

    property p_irq_cs_clear;
        @(posedge mclk) disable iff (!rst_n)
        (s_q.state == SPC_XFER && !cs_active) |=> !transfer_irq;
    endproperty
    a_irq_cs_clear: assert property (p_irq_cs_clear)
        else $error("interrupt still high after select rose");

    property p_irq_msb_clear;
        @(posedge mclk) disable iff (!rst_n)
        (s_q.state == SPC_XFER && cs_active && sample_edge && s_q.bit_cnt == 5'h00
         && !word_done) |=> !transfer_irq;
    endproperty
    a_irq_msb_clear: assert property (p_irq_msb_clear)
        else $error("interrupt not cleared on first bit of next word");

    property p_oe_release;
        @(posedge mclk) disable iff (!rst_n)
        (sdio_src_sel[1] && !cs_active) |=> !serial_out_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("data driver on while select inactive");

    property p_shift_out_oe;
        @(posedge mclk) disable iff (!rst_n)
        (phase_select_bit && parallel_to_serial_mode && sdio_src_sel == 2'h2 && cs_active)
            |=> serial_out_oe;
    endproperty
    a_shift_out_oe: assert property (p_shift_out_oe)
        else $error("data driver off during a shift-out frame");

    property p_phase0_no_shift_out;
        @(posedge mclk) disable iff (!rst_n)
        (!phase_select_bit && sdio_src_sel == 2'h2) |=> !serial_out_oe;
    endproperty
    a_phase0_no_shift_out: assert property (p_phase0_no_shift_out)
        else $error("shift output driven with phase 0");

    property p_sync_lead;
        @(posedge mclk) disable iff (!rst_n)
        (s_q.state == SPC_IDLE && cs_active && p2s_eff)
            |=> (sync_hold && cs_active) [*2] ##1 !sync_hold;
    endproperty
    a_sync_lead: assert property (p_sync_lead)
        else $error("sync not held for two cycles before load");

    property p_buffer_delay;
        @(posedge mclk) disable iff (!rst_n)
        (buffer_mode_en && bufclk_rise && par_src_adc)
            |=> serial_to_parallel_word[7:0] == $past(adc_word);
    endproperty
    a_buffer_delay: assert property (p_buffer_delay)
        else $error("buffered sample wrong one clock after buffer clock");

    property p_word_stable;
        @(posedge mclk) disable iff (!rst_n)
        (!word_done && !(buffer_mode_en && bufclk_rise)) |=> $stable(serial_to_parallel_word);
    endproperty
    a_word_stable: assert property (p_word_stable)
        else $error("parallel word changed without a complete word");

    property p_count_clear;
        @(posedge mclk) disable iff (!rst_n)
        !cs_active |=> s_q.bit_cnt == 5'h00;
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("bit count not cleared with select inactive");

    property p_pin_adc;
        @(posedge mclk) disable iff (!rst_n)
        (sdio_src_sel == 2'h3) |=> serial_out_line == $past(adc_serial_bit);
    endproperty
    a_pin_adc: assert property (p_pin_adc)
        else $error("pin does not follow converter serial output");

    property p_byte_push;
        @(posedge mclk) disable iff (!rst_n)
        (rx_word_valid && byte_mode_8) |-> rx_word_data[15:8] == 8'h00;
    endproperty
    a_byte_push: assert property (p_byte_push)
        else $error("upper byte not zero in 8-bit word");

endmodule
`default_nettype wire

// *** tb/spc_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ========
// Serial master model for the routed link.
module spc_master_model (
    // Clock and returned data.
    input  wire logic mclk,
    input  wire logic miso,
    // Link outputs.
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi
);
    logic        pol;
    logic        pha;
    logic [15:0] rx_q;

    // Idle link at time zero.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // Five mclk per level keeps the serial clock well under the sampling limit.
    task automatic xfer(input logic [15:0] w, input int nb);
        @(posedge mclk) sclk <= pol;
        repeat (4) @(posedge mclk);
        cs_n <= 1'b0;
        repeat (6) @(posedge mclk);
        for (int i = nb - 1; i >= 0; i--) begin
            if (!pha) mosi <= w[i];
            repeat (5) @(posedge mclk);
            sclk <= ~pol;
            if (pha) mosi <= w[i];
            if (!pha) rx_q <= {rx_q[14:0], miso};
            repeat (5) @(posedge mclk);
            sclk <= pol;
            if (pha) rx_q <= {rx_q[14:0], miso};
        end
        repeat (5) @(posedge mclk);
    endtask

    // A released data line shows the inverse of its last value.
    task automatic stop();
        @(posedge mclk) cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (60) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// *** tb/slave_spi_serial_parallel_converter_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module slave_spi_serial_parallel_converter_tb
    import spc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n, phase_select_bit, polarity_select_bit, buffer_mode_en, par_src_adc;
    logic byte_mode_8, parallel_to_serial_mode, serial_clock, chip_select_n_input;
    logic serial_in_line, serial_out_line, serial_out_oe, transfer_irq, matrix_out_bit;
    logic adc_serial_bit, routed_buffer_clock, sync_hold, rx_space_ok, rx_word_valid;
    logic rx_word_ready, sync_seen;
    logic [1:0]  sdio_src_sel;
    logic [7:0]  state_counter_a, state_counter_b, adc_word;
    logic [15:0] serial_to_parallel_word, rx_word_data, w;
    logic [15:0] q[$];
    int          num_errors = 0;
    int          cmp_count = 0;
    int          seed = 36;

    spc_core uut (.*);
    spc_master_model m (.mclk(mclk), .miso(serial_out_line), .sclk(serial_clock),
        .cs_n(chip_select_n_input), .mosi(serial_in_line));

    // ========
    // Clock and sync monitor.
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (!rst_n) sync_seen <= 1'b0;
        else if (sync_hold === 1'b1) sync_seen <= 1'b1;
    end

    // ========
    // Shared tasks.
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Configuration is only trusted at power-up, so every change goes through reset.
    task automatic setup(input logic [7:0] c);
        @(posedge mclk);
        {sdio_src_sel, buffer_mode_en, par_src_adc, byte_mode_8, parallel_to_serial_mode,
         polarity_select_bit, phase_select_bit} <= c;
        m.pol <= c[1];
        m.pha <= c[0];
        rst_n <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    task automatic final_report();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ========
    // Scenarios.
    initial begin
        {rst_n, phase_select_bit, polarity_select_bit, buffer_mode_en, par_src_adc, byte_mode_8,
         parallel_to_serial_mode, sdio_src_sel, matrix_out_bit, adc_serial_bit} = '0;
        {routed_buffer_clock, state_counter_a, state_counter_b, adc_word} = '0;
        rx_word_ready = 1'b1;
        // Every polarity, phase and length; phase 0 also asks for serial-out.
        for (int k = 0; k < 8; k++) begin
            setup({2'h2, 2'b00, k[2], ~k[1], k[0], k[1]});
            w = 16'($random(seed));
            m.xfer(w, k[2] ? 8 : 16);
            repeat (3) @(posedge mclk);
            chk("par", k[2] ? {8'h00, w[7:0]} : w, serial_to_parallel_word);
            chk("irq", {15'h0, k[1]}, {15'h0, transfer_irq});
            m.stop();
            chk("irq clr", 16'h0, {15'h0, transfer_irq});
            chk("oe off", 16'h0, {15'h0, serial_out_oe});
        end
        // Overfill the stalled word buffer in one long frame; the extra word is lost.
        setup(8'h83);
        rx_word_ready <= 1'b0;
        for (int k = 0; k <= FIFO_DEPTH; k++) begin
            w = 16'($random(seed));
            if (k < FIFO_DEPTH) q.push_back(w);
            m.xfer(w, 16);
            if (k == FIFO_DEPTH) m.stop();
        end
        chk("space", 16'h0, {15'h0, rx_space_ok});
        while (q.size() > 0) begin
            @(posedge mclk);
            chk("valid", 16'h1, {15'h0, rx_word_valid});
            chk("fifo", q.pop_front(), rx_word_data);
            rx_word_ready <= 1'b1;
            @(posedge mclk);
            rx_word_ready <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        chk("empty", 16'h0, {15'h0, rx_word_valid});
        // Shift out both counter bytes, then the converter byte, after the sync lead.
        for (int k = 0; k < 2; k++) begin
            setup(k ? 8'h9f : 8'h87);
            {adc_word, state_counter_b, state_counter_a} <= 24'($random(seed));
            m.xfer(16'h0000, k ? 8 : 16);
            w = k ? {8'h00, adc_word} : {state_counter_b, state_counter_a};
            chk("shift out", w, k ? {8'h00, m.rx_q[7:0]} : m.rx_q);
            chk("sync", 16'h1, {15'h0, sync_seen});
            chk("oe on", 16'h1, {15'h0, serial_out_oe});
            m.stop();
            chk("oe off", 16'h0, {15'h0, serial_out_oe});
        end
        // A routed clock rise captures the selected source.
        for (int k = 0; k < 2; k++) begin
            setup({2'h2, 1'b1, k[0], 4'h1});
            {adc_word, state_counter_a} <= 16'($random(seed));
            @(posedge mclk) routed_buffer_clock <= 1'b1;
            repeat (3) @(posedge mclk);
            chk("buffer", {8'h00, k ? adc_word : state_counter_a}, serial_to_parallel_word);
            routed_buffer_clock <= 1'b0;
        end
        // Routed matrix signal, then the converter serial bit, on the shared pin.
        for (int k = 0; k < 2; k++) begin
            setup(k ? 8'hc1 : 8'h01);
            {adc_serial_bit, matrix_out_bit} <= k ? 2'h2 : 2'h1;
            repeat (3) @(posedge mclk);
            chk("pin", {14'h0, ~k[0], 1'b1}, {14'h0, serial_out_oe, serial_out_line});
        end
        final_report();
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
